// *** hdl/rofc_top.sv ***
// rofc_top: ring oscillator frequency counter with its register port.
// assumes a one-cycle read/write strobe register port; read data the next cycle.
//
// Decided for this implementation: strobed register access.
`timescale 1ns/1ps
`default_nettype none

module rofc_top (
  input  wire logic                     core_clk,
  input  wire logic                     sys_rst,
  input  wire logic [rofc_pkg::ADDR_W-1:0] reg_addr,
  input  wire logic [31:0]              reg_wdata,
  input  wire logic [3:0]               reg_be,
  input  wire logic                     reg_wr,
  input  wire logic                     reg_rd,
  output logic [31:0]                   reg_rdata,
  input  wire logic                     osc_clk,
  output logic                          osc_enable,
  output logic                          irq
);
  import rofc_pkg::*;

  logic [31:0] rdata_ff;
  logic        enable_ff;
  logic        go_ff;
  logic        flag_ff;
  logic        irq_en_ff;
  logic [15:0] reload_ff;
  logic [15:0] downcnt_ff;
  logic [23:0] tally_ff;
  logic        irq_ff;
  logic        osc_rise;
  logic        wr_ctl;
  logic        wr_rel;
  logic        start;
  logic        underflow;
  logic [31:0] ctl_view;
  logic [31:0] reload_merged;

  // merge byte lanes of a write onto an old word
  function automatic logic [31:0] lane_merge(input logic [31:0] old_w,
                                             input logic [31:0] new_w,
                                             input logic [3:0]  be);
    logic [31:0] res;
    res = old_w;
    for (int i = 0; i < 4; i++)
    begin
      if (be[i])
        res[i*8 +: 8] = new_w[i*8 +: 8];
    end
    return res;
  endfunction

  // oscillator edge synchroniser
  rofc_edge_sync u_sync (
    .core_clk   (core_clk),
    .sys_rst    (sys_rst),
    .osc_in     (osc_clk),
    .rise_pulse (osc_rise)
  );

  // address decode; byte enables select lanes
  assign wr_ctl    = reg_wr && (reg_addr == OFS_CONTROL) && reg_be[0];
  assign wr_rel    = reg_wr && (reg_addr == OFS_RELOAD);
  assign start     = wr_ctl && reg_wdata[BIT_GO] && !go_ff;
  assign underflow = go_ff && !start && (downcnt_ff == 16'h0000);
  assign reload_merged = lane_merge({16'h0000, reload_ff}, reg_wdata, reg_be);

  assign ctl_view = {24'h000000, irq_en_ff, 2'b00, flag_ff, 2'b00, go_ff, enable_ff};

  // control bits: enable and irq enable
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      enable_ff <= 1'b0;
      irq_en_ff <= 1'b0;
    end
    else if (wr_ctl)
    begin
      enable_ff <= reg_wdata[BIT_ENABLE];
      irq_en_ff <= reg_wdata[BIT_IRQ_EN];
    end
  end

  // measurement go bit
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
      go_ff <= 1'b0;
    else if (wr_ctl)
      go_ff <= reg_wdata[BIT_GO];
    else if (underflow)
      go_ff <= 1'b0;
  end

  // flag: underflow set wins over software clear
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
      flag_ff <= 1'b0;
    else if (underflow)
      flag_ff <= 1'b1;
    else if (wr_ctl && reg_wdata[BIT_FLAG])
      flag_ff <= 1'b0;
  end

  // reload value register
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
      reload_ff <= RELOAD_RST;
    else if (wr_rel)
      reload_ff <= reload_merged[15:0];
  end

  // interval down counter
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
      downcnt_ff <= DOWNCNT_RST;
    else if (start)
      downcnt_ff <= reload_ff;
    else if (go_ff && downcnt_ff != 16'h0000)
      downcnt_ff <= downcnt_ff - 16'h0001;
  end

  // tally of oscillator edges during the window
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
      tally_ff <= TALLY_RST;
    else if (start)
      tally_ff <= TALLY_RST;
    else if (go_ff && osc_rise)
      tally_ff <= tally_ff + 24'h000001;
  end

  // interrupt request output
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
      irq_ff <= 1'b0;
    else
      irq_ff <= (flag_ff || underflow) && irq_en_ff;
  end

  // read data, valid the cycle after the strobe
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
      rdata_ff <= 32'h00000000;
    else if (reg_rd)
    begin
      case (reg_addr)
        OFS_CONTROL: rdata_ff <= ctl_view;
        OFS_RELOAD:  rdata_ff <= {16'h0000, reload_ff};
        OFS_DOWNCNT: rdata_ff <= {16'h0000, downcnt_ff};
        OFS_TALLY:   rdata_ff <= {8'h00, tally_ff};
        default:     rdata_ff <= 32'h00000000;
      endcase
    end
    else
      rdata_ff <= 32'h00000000;
  end

  assign reg_rdata  = rdata_ff;
  assign osc_enable = enable_ff;
  assign irq        = irq_ff;

  // binds software; no hardware check of the settle time

  chk_underflow_clears: assert property (@(posedge core_clk) disable iff (sys_rst)
    (underflow && !wr_ctl) |=> !go_ff)
    else $error("go not cleared at underflow");
  chk_flag_sets: assert property (@(posedge core_clk) disable iff (sys_rst)
    underflow |=> flag_ff)
    else $error("flag not set at underflow");
  chk_flag_clear: assert property (@(posedge core_clk) disable iff (sys_rst)
    (wr_ctl && reg_wdata[BIT_FLAG] && !underflow) |=> !flag_ff)
    else $error("flag not cleared by write one");
  chk_flag_keep: assert property (@(posedge core_clk) disable iff (sys_rst)
    (flag_ff && !(wr_ctl && reg_wdata[BIT_FLAG])) |=> flag_ff)
    else $error("flag lost without clear");
  chk_irq_gate: assert property (@(posedge core_clk) disable iff (sys_rst)
    !irq_en_ff |=> !irq_ff)
    else $error("irq while disabled");
  chk_irq_follow: assert property (@(posedge core_clk) disable iff (sys_rst)
    (flag_ff && irq_en_ff) |=> irq_ff)
    else $error("irq missing");
  chk_start_load: assert property (@(posedge core_clk) disable iff (sys_rst)
    start |=> (downcnt_ff == $past(reload_ff)) && (tally_ff == 24'h000000))
    else $error("start did not reload");
  chk_count_down: assert property (@(posedge core_clk) disable iff (sys_rst)
    (go_ff && !start && !wr_ctl && downcnt_ff != 16'h0000) |=> downcnt_ff == $past(downcnt_ff) - 16'h0001)
    else $error("interval counter stalled");
  chk_tally_idle: assert property (@(posedge core_clk) disable iff (sys_rst)
    (!go_ff && !start) |=> $stable(tally_ff))
    else $error("tally moved outside window");
  chk_enable_pin: assert property (@(posedge core_clk) disable iff (sys_rst)
    wr_ctl |=> osc_enable == $past(reg_wdata[BIT_ENABLE]))
    else $error("enable not applied");
  chk_enable_hold: assert property (@(posedge core_clk) disable iff (sys_rst)
    !wr_ctl |=> $stable(osc_enable))
    else $error("enable moved without write");

  // window length tracker: cycles spent counting since the last start
  logic [15:0] win_len_ff;
  logic [15:0] win_ref_ff;
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      win_len_ff <= 16'h0000;
      win_ref_ff <= RELOAD_RST;
    end
    else if (start)
    begin
      win_len_ff <= 16'h0000;
      win_ref_ff <= reload_ff;
    end
    else if (go_ff)
      win_len_ff <= win_len_ff + 16'h0001;
  end

  // window length and go bit life time
  chk_window_len: assert property (@(posedge core_clk) disable iff (sys_rst)
    underflow |-> win_len_ff == win_ref_ff)
    else $error("window length differs from reload");
  chk_go_hold: assert property (@(posedge core_clk) disable iff (sys_rst)
    (go_ff && !underflow && !wr_ctl) |=> go_ff)
    else $error("go dropped before underflow");
  chk_go_start: assert property (@(posedge core_clk) disable iff (sys_rst)
    start |=> go_ff)
    else $error("go not set by start");
  chk_go_stop: assert property (@(posedge core_clk) disable iff (sys_rst)
    (wr_ctl && !reg_wdata[BIT_GO]) |=> !go_ff)
    else $error("go not stopped by write zero");
  chk_stop_holds: assert property (@(posedge core_clk) disable iff (sys_rst)
    (!go_ff && !start) |=> $stable(downcnt_ff))
    else $error("interval counter moved while stopped");
  chk_no_restart: assert property (@(posedge core_clk) disable iff (sys_rst)
    (wr_ctl && go_ff && reg_wdata[BIT_GO] && downcnt_ff != 16'h0000) |=> downcnt_ff == $past(downcnt_ff) - 16'h0001)
    else $error("running window restarted");

  // tally counting only on oscillator edges
  chk_tally_step: assert property (@(posedge core_clk) disable iff (sys_rst)
    (go_ff && !start && osc_rise) |=> tally_ff == $past(tally_ff) + 24'h000001)
    else $error("tally missed an edge");
  chk_tally_hold: assert property (@(posedge core_clk) disable iff (sys_rst)
    (go_ff && !start && !osc_rise) |=> $stable(tally_ff))
    else $error("tally moved without edge");

  // flag and interrupt quiet paths
  chk_flag_quiet: assert property (@(posedge core_clk) disable iff (sys_rst)
    (!flag_ff && !underflow) |=> !flag_ff)
    else $error("flag set without underflow");
  chk_irq_drop: assert property (@(posedge core_clk) disable iff (sys_rst)
    (!flag_ff && !underflow) |=> !irq_ff)
    else $error("irq without flag");

  // byte lanes and read-only registers
  chk_ctl_lane: assert property (@(posedge core_clk) disable iff (sys_rst)
    (reg_wr && reg_addr == OFS_CONTROL && !reg_be[0]) |=> $stable(enable_ff) && $stable(irq_en_ff))
    else $error("control changed without byte lane 0");
  chk_reload_lane: assert property (@(posedge core_clk) disable iff (sys_rst)
    (wr_rel && !reg_be[1]) |=> reload_ff[15:8] == $past(reload_ff[15:8]))
    else $error("reload upper byte changed without its lane");
  chk_reload_low: assert property (@(posedge core_clk) disable iff (sys_rst)
    (wr_rel && reg_be[0]) |=> reload_ff[7:0] == $past(reg_wdata[7:0]))
    else $error("reload lower byte not written");
  chk_downcnt_ro: assert property (@(posedge core_clk) disable iff (sys_rst)
    (reg_wr && reg_addr == OFS_DOWNCNT && !go_ff) |=> $stable(downcnt_ff))
    else $error("interval counter written by software");
  chk_tally_ro: assert property (@(posedge core_clk) disable iff (sys_rst)
    (reg_wr && reg_addr == OFS_TALLY && !go_ff) |=> $stable(tally_ff))
    else $error("tally written by software");

  // read port contents
  chk_rdata_idle: assert property (@(posedge core_clk) disable iff (sys_rst)
    !reg_rd |=> reg_rdata == 32'h00000000)
    else $error("read data not zero outside read");
  chk_flag_read: assert property (@(posedge core_clk) disable iff (sys_rst)
    (reg_rd && reg_addr == OFS_CONTROL) |=> reg_rdata[BIT_FLAG] == $past(flag_ff))
    else $error("flag read back wrong");
  chk_tally_read: assert property (@(posedge core_clk) disable iff (sys_rst)
    (reg_rd && reg_addr == OFS_TALLY) |=> reg_rdata == {8'h00, $past(tally_ff)})
    else $error("tally read back wrong");
  chk_downcnt_read: assert property (@(posedge core_clk) disable iff (sys_rst)
    (reg_rd && reg_addr == OFS_DOWNCNT) |=> reg_rdata == {16'h0000, $past(downcnt_ff)})
    else $error("interval counter read back wrong");
  chk_reload_read: assert property (@(posedge core_clk) disable iff (sys_rst)
    (reg_rd && reg_addr == OFS_RELOAD) |=> reg_rdata == {16'h0000, $past(reload_ff)})
    else $error("reload read back wrong");
endmodule
`default_nettype wire

// *** hdl/rofc_pkg.sv ***
// rofc_pkg: register map, field positions, reset values and timing for the
// ring oscillator frequency counter.
// assumes a single 200 MHz core clock domain.
package rofc_pkg;
  localparam int          ADDR_W          = 4;
  localparam logic [3:0]  OFS_CONTROL     = 4'h0;
  localparam logic [3:0]  OFS_RELOAD      = 4'h4;
  localparam logic [3:0]  OFS_DOWNCNT     = 4'h8;
  localparam logic [3:0]  OFS_TALLY       = 4'hC;
  localparam int          BIT_ENABLE      = 0;
  localparam int          BIT_GO          = 1;
  localparam int          BIT_FLAG        = 4;
  localparam int          BIT_IRQ_EN      = 7;
  localparam int          INTERVAL_W      = 16;
  localparam int          TALLY_W         = 24;
  localparam logic [15:0] RELOAD_RST      = 16'hFFFF;
  localparam logic [15:0] DOWNCNT_RST     = 16'hFFFF;
  localparam logic [23:0] TALLY_RST       = 24'h000000;
  localparam int          CLK_MHZ         = 200;
  localparam int          SETTLE_US       = 500;
  localparam int          SETTLE_CYCLES   = SETTLE_US * CLK_MHZ;
  localparam int          SYNC_STAGES     = 2;
endpackage

// *** hdl/rofc_edge_sync.sv ***
// rofc_edge_sync: brings the asynchronous oscillator into the core clock
// domain and emits one pulse per rising oscillator edge.
// assumes the oscillator runs well below half the core clock rate.
`timescale 1ns/1ps
`default_nettype none
module rofc_edge_sync (
  input  wire logic core_clk,
  input  wire logic sys_rst,
  input  wire logic osc_in,
  output logic      rise_pulse
);
  import rofc_pkg::*;

  logic sync1_ff;
  logic sync2_ff;
  logic prev_ff;

  // two-stage synchroniser, then edge detect on the second stage only
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      sync1_ff <= 1'b0;
      sync2_ff <= 1'b0;
      prev_ff  <= 1'b0;
    end
    else
    begin
      sync1_ff <= osc_in;
      sync2_ff <= sync1_ff;
      prev_ff  <= sync2_ff;
    end
  end

  assign rise_pulse = sync2_ff & ~prev_ff;
endmodule
`default_nettype wire

// *** testbench/rofc_osc_model.sv ***
// rofc_osc_model: behavioural ring oscillator feeding the counter.
// assumes the block drives osc_enable; output rests low while off.
`timescale 1ns/1ps
`default_nettype none
module rofc_osc_model #(
  parameter int HALF_NS = 17
) (
  input  wire logic osc_enable,
  output logic      osc_clk
);
  // toggle only while powered, else stand still low
  initial
  begin
    osc_clk = 1'b0;
    forever
    begin
      #HALF_NS;
      osc_clk = osc_enable ? ~osc_clk : 1'b0;
    end
  end
endmodule
`default_nettype wire

// *** testbench/tb_ring_osc_frequency_counter.sv ***
// tb_ring_osc_frequency_counter: self-checking bench for rofc_top.
// assumes rofc_osc_model as the sensing element; 200 MHz core clock.
`timescale 1ns/1ps
`default_nettype none
module tb_ring_osc_frequency_counter;
  import rofc_pkg::*;
  logic        core_clk, sys_rst, reg_wr, reg_rd, osc_clk, osc_enable, irq;
  logic [3:0]  reg_addr, reg_be;
  logic [31:0] reg_wdata, reg_rdata, got;
  int          n_mismatch, checks_done, rl, n;
  int          mdl [int];

  rofc_top rofc_top_inst (.core_clk(core_clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_be(reg_be), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .osc_clk(osc_clk), .osc_enable(osc_enable), .irq(irq));
  rofc_osc_model rofc_osc_model_inst (.osc_enable(osc_enable), .osc_clk(osc_clk));

  // core clock, 5 ns period
  initial
  begin
    core_clk = 1'b0;
    forever
      #2.5 core_clk = ~core_clk;
  end

  task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // one-cycle write strobe
  task automatic wr(logic [3:0] a, logic [31:0] d, logic [3:0] be);
    @(posedge core_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    reg_be    <= be;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask

  // one-cycle read strobe, data taken in the following cycle
  task automatic rd(logic [3:0] a);
    @(posedge core_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 got = reg_rdata;
  endtask

  task automatic rdchk(logic [3:0] a, logic [31:0] exp, string what);
    rd(a);
    check(what, got, exp);
  endtask

  // bounded wait for the interrupt, counting edges
  task automatic wait_irq(int lim);
    n = 0;
    while (irq !== 1'b1 && n < lim)
    begin
      @(posedge core_clk);
      #1 n++;
    end
    if (n == lim)
    begin
      n_mismatch++;
      conclude();
    end
  endtask

  // main sequence
  initial
  begin
    sys_rst   = 1'b1;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    reg_addr  = 4'h0;
    reg_wdata = 32'h0;
    reg_be    = 4'h0;
    n = $urandom(68);
    mdl = '{0: 0, 4: 'hFFFF, 8: 'hFFFF, 12: 0};
    repeat (10) @(posedge core_clk);
    sys_rst <= 1'b0;
    for (int a = 0; a < 16; a++)
      rdchk(a[3:0], mdl.exists(a) ? mdl[a] : 0, "reset_map");
    $display("test reset map done");
    wr(4'h4, 32'h12345678, 4'b0001);
    rdchk(4'h4, 32'h0000FF78, "reload_be");
    rl = 20 + $urandom % 100;
    wr(4'h4, rl, 4'hF);
    wr(4'h8, 32'hFFFFFFFF, 4'hF);
    wr(4'hC, 32'hFFFFFFFF, 4'hF);
    rdchk(4'h8, 32'h0000FFFF, "downcnt_ro");
    rdchk(4'hC, 32'h0, "tally_ro");
    rdchk(4'h4, rl, "reload");
    wr(4'h0, 32'h81, 4'h1);
    #1 check("osc_on", osc_enable, 1);
    repeat (20) @(posedge core_clk);
    wr(4'h0, 32'h83, 4'h1);
    wait_irq(rl + 10);
    check("window", n, rl + 1);
    rdchk(4'h0, 32'h91, "ctl_done");
    rd(4'hC);
    check("tally_rsvd", got[31:24], 8'h00);
    n = int'(got) - (rl + 1) * 5 / 34;
    check("tally_near", n >= -2 && n <= 2, 1);
    $display("test measure done");
    wr(4'h0, 32'h81, 4'h1);
    rdchk(4'h0, 32'h91, "flag_keep");
    wr(4'h0, 32'h91, 4'h1);
    rdchk(4'h0, 32'h81, "flag_clr");
    check("irq_clr", irq, 0);
    wr(4'h0, 32'h00, 4'h1);
    #1 check("osc_off", osc_enable, 0);
    repeat (8) @(posedge core_clk);
    wr(4'h0, 32'h02, 4'h1);
    repeat (rl + 4) @(posedge core_clk);
    #1 check("irq_mask", irq, 0);
    rdchk(4'h0, 32'h10, "ctl_mask");
    rdchk(4'hC, 32'h0, "tally_off");
    wr(4'h0, 32'h81, 4'h1);
    @(posedge core_clk);
    #1 check("irq_unmask", irq, 1);
    $display("test irq done");
    wr(4'h0, 32'h93, 4'h1);
    repeat (5) @(posedge core_clk);
    wr(4'h0, 32'h81, 4'h1);
    rdchk(4'h0, 32'h81, "ctl_stop");
    rdchk(4'h8, rl - 7, "downcnt_rd");
    rdchk(4'h8, got, "downcnt_held");
    check("downcnt_run", got < rl, 1);
    $display("test stop done");
    conclude();
  end
endmodule
`default_nettype wire
